// >>> hdl/tfas_alarm_status.sv
// second-order framer alarm detection, clear-on-read status and summary over AHB-Lite
`timescale 1ns/1ps
// Contract
// R1: per-framer frame loss latch, read clears unless active
// R2: frame loss change raises summary when enabled, masked
// R3: frame loss enable in first register bit 7
// R4: E3 leaves framers five to seven meaningless
// R5: all-ones latches in bits 8 to 14
// R6: AIS change raises summary when bit 15 set
// R7: E3 leaves upper AIS latches meaningless
// R8: reading first register clears its latches
// R9: remote alarm latches in second register bits 0-6
// R10: remote alarm change raises second summary bit
// R11: E3 leaves upper remote alarm latches meaningless
// R12: bits 8-11 show live E2 national bit
// R13: bits 12-15 latch each E2 frame start
// R14: reading second register clears its latches
// R15: T2 AIS set at eight zeros in 4704
// R16: T2 AIS clears at nine zeros or more
// R17: T2 loss on 2/5 F or 2/4 M errors
// R18: T2 remote alarm from X over four frames
// R19: E2 AIS over two 848-bit frames
// R20: E2/G.747 loss four bad, clear three good
// R21: E2 remote alarm from bit 11, four frames
// R22: G.747 uses 840-bit frames, set 2 bit 1
// R23: operating mode is a static input
// R24: set in the clearing cycle wins
module tfas_alarm_status (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire tfas_pkg::tfas_mode_e op_mode,
  input wire tfas_pkg::tfas_obs_s [6:0] framer_obs,
  input wire logic [1:0] master_status_mask,
  output logic [1:0] master_status_sum,
  output logic framer_irq
);

  typedef struct packed {
    logic ph_wr;
    logic ph_sr1;
    logic ph_sr2;
    logic [31:0] rdata;
    logic frame_loss_irq_enable;
    logic all_ones_irq_enable;
    logic remote_alarm_irq_enable;
    tfas_pkg::tfas_alm_s [6:0] alm_prev;
    logic [3:0] e2_received_national_bit;
    logic [1:0] sum;
  } tfas_top_s;

  tfas_top_s s_q;
  tfas_top_s s_d;

  logic [6:0] active;
  logic is_e2;
  tfas_pkg::tfas_alm_s [6:0] alm;
  logic [6:0] lof_lvl;
  logic [6:0] ais_lvl;
  logic [6:0] rai_lvl;
  logic [3:0] sof_ev;
  logic [13:0] sr1_lat;
  logic [10:0] sr2_lat;
  logic [1:0] chg1_set;
  logic [1:0] chg1_lat;
  logic chg2_set;
  logic chg2_lat;
  logic acc;
  logic hit1;
  logic hit2;
  logic rd_sr1;
  logic rd_sr2;
  logic wr1_now;
  logic wr2_now;
  logic ie_lof_cur;
  logic ie_ais_cur;
  logic ie_rai_cur;
  logic [15:0] sr1_val;
  logic [15:0] sr2_val;

  // mode picks the criteria; E3 runs only four E2 framers
  assign is_e2 = (op_mode == tfas_pkg::TFAS_MODE_E2); // R23

  // one detector per framer
  for (genvar i = 0; i < tfas_pkg::TFAS_NFR; i++) begin : g_fr
    assign active[i] = !is_e2 || (i < tfas_pkg::TFAS_NE2); // R4 R7 R11
    tfas_detector u_det (
      .hclk(hclk),
      .hresetn(hresetn),
      .mode(op_mode),
      .active(active[i]),
      .obs(framer_obs[i]),
      .alm(alm[i])
    );
    assign lof_lvl[i] = alm[i].lof;
    assign ais_lvl[i] = alm[i].ais;
    assign rai_lvl[i] = alm[i].rai;
  end

  // E2 frame boundaries for the start-of-frame latches
  for (genvar j = 0; j < tfas_pkg::TFAS_NE2; j++) begin : g_sof
    assign sof_ev[j] = is_e2 && framer_obs[j].frm_start; // R13
  end

  // bus decode; a read clears in the cycle it samples the latches
  assign acc = hsel && hready && (htrans == tfas_pkg::TFAS_HTRANS_NONSEQ);
  assign hit1 = (haddr == tfas_pkg::TFAS_SR1_ADDR);
  assign hit2 = (haddr == tfas_pkg::TFAS_SR2_ADDR);
  assign rd_sr1 = acc && !hwrite && hit1; // R8
  assign rd_sr2 = acc && !hwrite && hit2; // R14

  // a write in its data phase is forwarded so a following read sees it
  assign wr1_now = s_q.ph_wr && s_q.ph_sr1;
  assign wr2_now = s_q.ph_wr && s_q.ph_sr2;
  assign ie_lof_cur = wr1_now ? hwdata[tfas_pkg::TFAS_IE_LOF_BIT] : s_q.frame_loss_irq_enable; // R3
  assign ie_ais_cur = wr1_now ? hwdata[tfas_pkg::TFAS_IE_AIS_BIT] : s_q.all_ones_irq_enable; // R6
  assign ie_rai_cur = wr2_now ? hwdata[tfas_pkg::TFAS_IE_RAI_BIT] : s_q.remote_alarm_irq_enable; // R10

  // status latches: level inputs keep a bit set while the alarm stands
  tfas_latch #(
    .W(14)
  ) u_sr1_lat (
    .hclk(hclk),
    .hresetn(hresetn),
    .set({ais_lvl, lof_lvl}), // R1 R5
    .clr(rd_sr1),
    .q(sr1_lat)
  );

  tfas_latch #(
    .W(11)
  ) u_sr2_lat (
    .hclk(hclk),
    .hresetn(hresetn),
    .set({sof_ev, rai_lvl}), // R9 R13
    .clr(rd_sr2),
    .q(sr2_lat)
  );

  // change-of-state events feed the summary; reading drops the request
  assign chg1_set[0] = |(lof_lvl ^ {s_q.alm_prev[6].lof, s_q.alm_prev[5].lof, s_q.alm_prev[4].lof,
                                  s_q.alm_prev[3].lof, s_q.alm_prev[2].lof, s_q.alm_prev[1].lof,
                                  s_q.alm_prev[0].lof}); // R2
  assign chg1_set[1] = |(ais_lvl ^ {s_q.alm_prev[6].ais, s_q.alm_prev[5].ais, s_q.alm_prev[4].ais,
                                  s_q.alm_prev[3].ais, s_q.alm_prev[2].ais, s_q.alm_prev[1].ais,
                                  s_q.alm_prev[0].ais}); // R6
  assign chg2_set = |(rai_lvl ^ {s_q.alm_prev[6].rai, s_q.alm_prev[5].rai, s_q.alm_prev[4].rai,
                               s_q.alm_prev[3].rai, s_q.alm_prev[2].rai, s_q.alm_prev[1].rai,
                               s_q.alm_prev[0].rai}); // R10

  tfas_latch #(
    .W(2)
  ) u_chg1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(chg1_set),
    .clr(rd_sr1),
    .q(chg1_lat)
  );

  tfas_latch #(
    .W(1)
  ) u_chg2 (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(chg2_set),
    .clr(rd_sr2),
    .q(chg2_lat)
  );

  // register images, upper half reads zero
  assign sr1_val = {ie_ais_cur, sr1_lat[13:7], ie_lof_cur, sr1_lat[6:0]}; // R3 R5
  assign sr2_val = {sr2_lat[10:7], s_q.e2_received_national_bit, ie_rai_cur, sr2_lat[6:0]}; // R9 R12 R13

  // bus phase tracking, enables, national bits and summary
  always_comb begin
    s_d = s_q;
    s_d.alm_prev = alm;
    s_d.frame_loss_irq_enable = ie_lof_cur;
    s_d.all_ones_irq_enable = ie_ais_cur;
    s_d.remote_alarm_irq_enable = ie_rai_cur;
    if (hready) begin
      s_d.ph_wr = acc && hwrite;
      s_d.ph_sr1 = acc && hit1;
      s_d.ph_sr2 = acc && hit2;
    end
    // read data is registered at the address phase, unmapped reads as zero
    if (acc && !hwrite) begin
      if (hit1) begin
        s_d.rdata = {16'h0000, sr1_val};
      end else if (hit2) begin
        s_d.rdata = {16'h0000, sr2_val};
      end else begin
        s_d.rdata = 32'h00000000;
      end
    end
    // live national bit, reloaded as each E2 frame decodes it
    for (int k = 0; k < tfas_pkg::TFAS_NE2; k++) begin
      if (is_e2 && framer_obs[k].sn_seen) begin
        s_d.e2_received_national_bit[k] = framer_obs[k].sn_bit; // R12
      end
    end
    // enable and master mask both gate; national and frame start never do
    s_d.sum[0] = master_status_mask[0] &&
                 ((s_q.frame_loss_irq_enable && chg1_lat[0]) || (s_q.all_ones_irq_enable && chg1_lat[1])); // R2 R6
    s_d.sum[1] = master_status_mask[1] && s_q.remote_alarm_irq_enable && chg2_lat; // R10
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.frame_loss_irq_enable <= tfas_pkg::TFAS_IE_RESET;
      s_q.all_ones_irq_enable <= tfas_pkg::TFAS_IE_RESET;
      s_q.remote_alarm_irq_enable <= tfas_pkg::TFAS_IE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // zero-wait slave, always OKAY
  assign hreadyout = 1'h1;
  assign hresp = tfas_pkg::TFAS_HRESP_OKAY;
  assign hrdata = s_q.rdata;
  assign master_status_sum = s_q.sum;
  assign framer_irq = |s_q.sum;

endmodule

// >>> hdl/tfas_pkg.sv
// shared constants, types and register map of the second-order framer alarm status block
package tfas_pkg;

  // operating selection, one-hot: T3 (T2 framers), E3 (E2 framers), G.747
  typedef enum logic [2:0] {
    TFAS_MODE_T2 = 3'h1,
    TFAS_MODE_E2 = 3'h2,
    TFAS_MODE_G747 = 3'h4
  } tfas_mode_e;

  localparam int TFAS_NFR = 7;
  localparam int TFAS_NE2 = 4;

  // per-framer observations from the alignment datapath, one cycle each
  typedef struct packed {
    logic bit_vld;   // a received bit is present
    logic bit_dat;   // its value
    logic frm_start; // first bit of a frame (M frame or E2/G.747 frame)
    logic fa_seen;   // F bit (T2) or FAS word (E2/G.747) checked
    logic fa_err;    // that check failed
    logic m_seen;    // M bit checked (T2 only)
    logic m_err;     // that check failed
    logic sync_gain; // alignment regained (T2)
    logic ind_seen;  // remote alarm indicator sampled
    logic ind_bit;   // X bit, E2 bit 11 or G.747 set 2 bit 1
    logic sn_seen;   // E2 national bit decoded
    logic sn_bit;
  } tfas_obs_s;

  typedef struct packed {
    logic rai;
    logic ais;
    logic lof;
  } tfas_alm_s;

  // AIS zero-count windows in bits: 4704, 848, 840
  localparam logic [12:0] TFAS_T2_WIN_BITS = 13'h1260;
  localparam logic [12:0] TFAS_E2_WIN_BITS = 13'h0350;
  localparam logic [12:0] TFAS_G747_WIN_BITS = 13'h0348;
  localparam logic [12:0] TFAS_T2_AIS_MAX_ZEROS = 13'h0008;
  localparam logic [12:0] TFAS_E2_AIS_MAX_ZEROS = 13'h0004;

  // frame loss and remote alarm persistence counts
  localparam int TFAS_T2_ERR_MIN = 2;
  localparam logic [2:0] TFAS_FAS_BAD_RUN = 3'h4;
  localparam logic [2:0] TFAS_FAS_GOOD_RUN = 3'h3;
  localparam logic [2:0] TFAS_RAI_RUN = 3'h4;

  // register indices; byte address is four times the index
  localparam logic [7:0] TFAS_SR1_IDX = 8'h34;
  localparam logic [7:0] TFAS_SR2_IDX = 8'h36;
  localparam logic [31:0] TFAS_SR1_ADDR = {22'h000000, TFAS_SR1_IDX, 2'h0};
  localparam logic [31:0] TFAS_SR2_ADDR = {22'h000000, TFAS_SR2_IDX, 2'h0};

  // field positions
  localparam int TFAS_IE_LOF_BIT = 7;
  localparam int TFAS_IE_AIS_BIT = 15;
  localparam int TFAS_IE_RAI_BIT = 7;

  localparam logic TFAS_IE_RESET = 1'h0;
  localparam logic [1:0] TFAS_HTRANS_NONSEQ = 2'h2;
  localparam logic TFAS_HRESP_OKAY = 1'h0;

endpackage

// >>> hdl/tfas_latch.sv
// clear-on-read sticky latches where a set in the clearing cycle wins
`timescale 1ns/1ps
module tfas_latch #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] set,
  input wire logic clr,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] q;
  } tfas_lat_s;

  tfas_lat_s s_q;
  tfas_lat_s s_d;

  // a level held on set keeps the bit through a read
  always_comb begin
    s_d.q = set | (s_q.q & ~{W{clr}}); // R24
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.q;

endmodule

// >>> hdl/tfas_detector.sv
// per-framer frame loss, all-ones and remote alarm detectors
`timescale 1ns/1ps
module tfas_detector (
  input wire logic hclk,
  input wire logic hresetn,
  input wire tfas_pkg::tfas_mode_e mode,
  input wire logic active,
  input wire tfas_pkg::tfas_obs_s obs,
  output tfas_pkg::tfas_alm_s alm
);

  typedef struct packed {
    logic [12:0] bitcnt;
    logic [12:0] zcnt;
    logic prev_low;
    logic [4:0] fwin;
    logic [3:0] mwin;
    logic [2:0] badcnt;
    logic [2:0] goodcnt;
    logic [2:0] raicnt;
    tfas_pkg::tfas_alm_s alm;
  } tfas_det_s;

  tfas_det_s s_q;
  tfas_det_s s_d;
  logic t2;
  logic low;
  logic act;
  logic [12:0] winlen;
  logic [12:0] b;
  logic [12:0] z;
  logic [4:0] fw;
  logic [3:0] mw;

  always_comb begin
    s_d = s_q;
    t2 = (mode == tfas_pkg::TFAS_MODE_T2);
    low = 1'h0;
    act = 1'h0;
    fw = s_q.fwin;
    mw = s_q.mwin;
    case (mode)
      tfas_pkg::TFAS_MODE_T2: winlen = tfas_pkg::TFAS_T2_WIN_BITS; // R15
      tfas_pkg::TFAS_MODE_E2: winlen = tfas_pkg::TFAS_E2_WIN_BITS; // R19
      tfas_pkg::TFAS_MODE_G747: winlen = tfas_pkg::TFAS_G747_WIN_BITS; // R22
      default: winlen = tfas_pkg::TFAS_T2_WIN_BITS;
    endcase
    // an E2/G.747 frame start realigns the window; a T2 M frame is only a quarter of it,
    // so the T2 window runs free over any 4704 received bits
    b = (obs.frm_start && !t2) ? 13'h0000 : s_q.bitcnt;
    z = (obs.frm_start && !t2) ? 13'h0000 : s_q.zcnt;
    if (obs.bit_vld) begin
      z = z + {12'h000, ~obs.bit_dat};
      b = b + 13'h0001;
      if (b == winlen) begin
        if (t2) begin
          s_d.alm.ais = (z <= tfas_pkg::TFAS_T2_AIS_MAX_ZEROS); // R15 R16
        end else begin
          low = (z <= tfas_pkg::TFAS_E2_AIS_MAX_ZEROS);
          // two frames in a row must agree before AIS moves
          if (low && s_q.prev_low) begin
            s_d.alm.ais = 1'h1; // R19 R22
          end else if (!low && !s_q.prev_low) begin
            s_d.alm.ais = 1'h0; // R19 R22
          end
          s_d.prev_low = low;
        end
        b = 13'h0000;
        z = 13'h0000;
      end
    end
    s_d.bitcnt = b;
    s_d.zcnt = z;
    // frame loss
    if (t2) begin
      if (obs.fa_seen) begin
        fw = {s_q.fwin[3:0], obs.fa_err};
      end
      if (obs.m_seen) begin
        mw = {s_q.mwin[2:0], obs.m_err};
      end
      s_d.fwin = fw;
      s_d.mwin = mw;
      if (($countones(fw) >= tfas_pkg::TFAS_T2_ERR_MIN) || ($countones(mw) >= tfas_pkg::TFAS_T2_ERR_MIN)) begin
        s_d.alm.lof = 1'h1; // R17
      end
      if (obs.sync_gain) begin
        s_d.alm.lof = 1'h0; // R17
        s_d.fwin = 5'h00;
        s_d.mwin = 4'h0;
      end
    end else if (obs.fa_seen) begin
      if (obs.fa_err) begin
        s_d.goodcnt = 3'h0;
        if (s_q.badcnt != tfas_pkg::TFAS_FAS_BAD_RUN) begin
          s_d.badcnt = s_q.badcnt + 3'h1;
        end
        if (s_d.badcnt == tfas_pkg::TFAS_FAS_BAD_RUN) begin
          s_d.alm.lof = 1'h1; // R20
        end
      end else begin
        s_d.badcnt = 3'h0;
        if (s_q.goodcnt != tfas_pkg::TFAS_FAS_GOOD_RUN) begin
          s_d.goodcnt = s_q.goodcnt + 3'h1;
        end
        if (s_d.goodcnt == tfas_pkg::TFAS_FAS_GOOD_RUN) begin
          s_d.alm.lof = 1'h0; // R20
        end
      end
    end
    // remote alarm: X is active low, the E2/G.747 bit active high
    if (obs.ind_seen) begin
      act = t2 ? ~obs.ind_bit : obs.ind_bit;
      if (act == s_q.alm.rai) begin
        s_d.raicnt = 3'h0;
      end else begin
        s_d.raicnt = s_q.raicnt + 3'h1;
        if (s_d.raicnt == tfas_pkg::TFAS_RAI_RUN) begin
          s_d.alm.rai = act; // R18 R21 R22
          s_d.raicnt = 3'h0;
        end
      end
    end
    // an unused framer is held quiet
    if (!active) begin
      s_d = '0; // R4 R7 R11
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign alm = s_q.alm;

endmodule

// >>> bench/tfas_host.sv
// behavioural AHB-Lite host that issues single word transfers
`timescale 1ns/1ps
module tfas_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h00000000,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h00000000
);
  logic tmo = 1'b0;

  // each phase is held until hready is sampled high; a stuck bus sets tmo
  task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= we;
    htrans <= tfas_pkg::TFAS_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 16) begin
      n++;
      @(posedge hclk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 32) begin
      n++;
      @(posedge hclk);
    end
    rd = hrdata;
    // released data lines flip so a stale value is never mistaken for a match
    hwdata <= ~wd;
    if (n >= 16) tmo = 1'b1;
  endtask
endmodule

// >>> bench/tfas_alarm_status_checker.sv
// concurrent checks on the ports of the framer alarm status block
`timescale 1ns/1ps
module tfas_alarm_status_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire tfas_pkg::tfas_mode_e op_mode,
  input wire logic [1:0] master_status_mask,
  input wire logic [1:0] master_status_sum,
  input wire logic framer_irq
);
  logic rd_req;
  logic e2;
  // read address phase as the slave takes it
  assign rd_req = hsel && hready && htrans == tfas_pkg::TFAS_HTRANS_NONSEQ && !hwrite;
  assign e2 = op_mode == tfas_pkg::TFAS_MODE_E2;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // summary bits are registered, so the mask acts one edge later
  sum0_mask_a: assert property (!master_status_mask[0] |=> !master_status_sum[0])
    else $error("summary 0 set while masked");
  sum1_mask_a: assert property (!master_status_mask[1] |=> !master_status_sum[1])
    else $error("summary 1 set while masked");
  // irq is the plain OR of the registered summary, so it never lags
  irq_quiet_a: assert property (!(|master_status_sum) |-> !framer_irq)
    else $error("irq without summary");
  irq_follow_a: assert property ((|master_status_sum) |-> framer_irq)
    else $error("summary without irq");
  e2_quiet1_a: assert property (rd_req && haddr == tfas_pkg::TFAS_SR1_ADDR && e2
    |=> hrdata[6:4] == 3'h0 && hrdata[14:12] == 3'h0) else $error("unused framer bits set in SR1");
  e2_quiet2_a: assert property (rd_req && haddr == tfas_pkg::TFAS_SR2_ADDR && e2 |=> hrdata[6:4] == 3'h0)
    else $error("unused framer bits set in SR2");
  sof_gate_a: assert property (rd_req && haddr == tfas_pkg::TFAS_SR2_ADDR && !e2 |=> hrdata[15:12] == 4'h0)
    else $error("frame start outside E2");
  rdata_hold_a: assert property (!rd_req |=> $stable(hrdata))
    else $error("read data moved without a read");
endmodule

bind tfas_alarm_status tfas_alarm_status_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .op_mode(op_mode), .master_status_mask(master_status_mask),
  .master_status_sum(master_status_sum), .framer_irq(framer_irq)
);

// >>> bench/tfas_alarm_status_tb_top.sv
// self-checking bench for the framer alarm status block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module tfas_alarm_status_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, framer_irq;
  logic [1:0] htrans, master_status_sum;
  logic [1:0] master_status_mask = 2'h3;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  tfas_pkg::tfas_mode_e op_mode = tfas_pkg::TFAS_MODE_T2;
  tfas_pkg::tfas_obs_s [6:0] obs = '0;
  int bad_count = 0;
  int checked = 0;
  localparam logic [31:0] A1 = tfas_pkg::TFAS_SR1_ADDR;
  localparam logic [31:0] A2 = tfas_pkg::TFAS_SR2_ADDR;
  localparam logic [31:0] AX = 32'h000000D4;

  // 200 MHz clock
  initial forever #2.5 hclk = ~hclk;

  tfas_alarm_status u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .op_mode(op_mode), .framer_obs(obs),
    .master_status_mask(master_status_mask), .master_status_sum(master_status_sum), .framer_irq(framer_irq)
  );
  tfas_host u_host (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // bus wrappers; a host timeout ends the run as a mismatch
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_host.xfer(1'b0, a, 32'h00000000, d);
    `CHK(d, e)
    if (u_host.tmo === 1'b1) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] d;
    u_host.xfer(1'b1, a, v, d);
  endtask

  // mode only changes under reset, since detectors treat it as static
  task automatic rst(input tfas_pkg::tfas_mode_e m);
    hresetn <= 1'b0;
    op_mode <= m;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  // n one-cycle observations on the framers in m: 0 alignment, 1 indicator, 2 resync, 3 frame start, 4 M bit
  task automatic hit(input logic [6:0] m, input int k, input logic b, input int n);
    tfas_pkg::tfas_obs_s o;
    repeat (n) begin
      o = '0;
      case (k)
        0: begin
          o.fa_seen = 1'b1;
          o.fa_err = b;
        end
        1: begin
          o.ind_seen = 1'b1;
          o.ind_bit = b;
        end
        2: o.sync_gain = 1'b1;
        4: begin
          o.m_seen = 1'b1;
          o.m_err = b;
        end
        default: begin
          o.frm_start = 1'b1;
          o.sn_seen = 1'b1;
          o.sn_bit = b;
        end
      endcase
      for (int i = 0; i < 7; i++) if (m[i]) obs[i] <= o;
      @(posedge hclk);
      obs <= '0;
      @(posedge hclk);
    end
    // level, latch and summary each take one more edge
    repeat (4) @(posedge hclk);
  endtask

  // one zero-count window on framer 1, zeros first
  task automatic win(input int len, input int nz);
    for (int i = 0; i < len; i++) begin
      obs[0].bit_vld <= 1'b1;
      obs[0].bit_dat <= (i >= nz);
      obs[0].frm_start <= (i == 0);
      @(posedge hclk);
    end
    obs <= '0;
    repeat (4) @(posedge hclk);
  endtask

  // reset values, enable bits, read-only latches, unmapped word
  task automatic s_regs();
    rd(A1, 32'h00000000);
    rd(A2, 32'h00000000);
    wr(A1, 32'h0000FFFF);
    wr(A2, 32'h0000FFFF);
    wr(AX, 32'h0000FFFF);
    rd(A1, 32'h00008080);
    rd(A2, 32'h00000080);
    rd(AX, 32'h00000000);
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
  endtask

  // remote alarm on framer 2: three samples fall short, the fourth declares
  task automatic s_rai();
    hit(7'h02, 1, 1'b0, 3);
    rd(A2, 32'h00000080);
    hit(7'h02, 1, 1'b0, 1);
    `CHK(master_status_sum, 2'h2)
    `CHK(framer_irq, 1'b1)
    rd(A2, 32'h00000082);
    rd(A2, 32'h00000082);
    repeat (4) @(posedge hclk);
    `CHK(master_status_sum, 2'h0)
    master_status_mask <= 2'h0;
    hit(7'h02, 1, 1'b1, 4);
    `CHK(master_status_sum, 2'h0)
    master_status_mask <= 2'h3;
    repeat (2) @(posedge hclk);
    `CHK(master_status_sum, 2'h2)
    rd(A2, 32'h00000082);
    rd(A2, 32'h00000080);
  endtask

  // T2 all-ones: nine zeros is clean, eight declares
  task automatic s_ais();
    win(4704, 9);
    rd(A1, 32'h00008080);
    win(4704, 8);
    `CHK(master_status_sum[0], 1'b1)
    rd(A1, 32'h00008180);
    win(4704, 9);
    rd(A1, 32'h00008180);
    rd(A1, 32'h00008080);
  endtask

  // T2 frame loss: F errors five samples apart or M errors four apart do not count, two closer do
  task automatic s_lof();
    hit(7'h01, 0, 1'b1, 1);
    hit(7'h01, 0, 1'b0, 4);
    hit(7'h01, 0, 1'b1, 1);
    rd(A1, 32'h00008080);
    hit(7'h01, 0, 1'b1, 1);
    rd(A1, 32'h00008081);
    hit(7'h01, 2, 1'b0, 1);
    rd(A1, 32'h00008081);
    rd(A1, 32'h00008080);
    hit(7'h01, 4, 1'b1, 1);
    hit(7'h01, 4, 1'b0, 3);
    hit(7'h01, 4, 1'b1, 1);
    rd(A1, 32'h00008080);
    hit(7'h01, 4, 1'b1, 1);
    rd(A1, 32'h00008081);
    hit(7'h01, 2, 1'b0, 1);
    rd(A1, 32'h00008081);
    rd(A1, 32'h00008080);
  endtask

  // E2 and G.747 on framers 1 and 5; framer 5 is idle in E2
  task automatic s_e2(input tfas_pkg::tfas_mode_e m, input int len);
    logic e2;
    logic [31:0] f;
    e2 = (m == tfas_pkg::TFAS_MODE_E2);
    f = e2 ? 32'h00000001 : 32'h00000011;
    rst(m);
    hit(7'h11, 3, 1'b1, 1);
    rd(A2, e2 ? 32'h00001100 : 32'h00000000);
    rd(A2, e2 ? 32'h00000100 : 32'h00000000);
    win(len, 4);
    rd(A1, 32'h00000000);
    win(len, 4);
    rd(A1, 32'h00000100);
    hit(7'h11, 0, 1'b1, 3);
    rd(A1, 32'h00000100);
    hit(7'h11, 0, 1'b1, 1);
    rd(A1, 32'h00000100 | f);
    hit(7'h11, 0, 1'b0, 2);
    rd(A1, 32'h00000100 | f);
    rd(A1, 32'h00000100 | f);
    hit(7'h11, 0, 1'b0, 1);
    rd(A1, 32'h00000100 | f);
    rd(A1, 32'h00000100);
    hit(7'h11, 1, 1'b1, 4);
    rd(A2, e2 ? 32'h00001101 : 32'h00000011);
  endtask

  // main sequence over all three operating selections
  initial begin
    rst(tfas_pkg::TFAS_MODE_T2);
    s_regs();
    s_rai();
    s_ais();
    s_lof();
    s_e2(tfas_pkg::TFAS_MODE_E2, 848);
    s_e2(tfas_pkg::TFAS_MODE_G747, 840);
    stop_test();
  end
endmodule
